//--- src/etp_top.sv
// Three energy-to-pulse converters with their registers and pins
//
// How it works
// - Three converters, each driving its own pin
// - Fast capture enabled silences the third pin
// - Phase fields at compute bits 2:0,5:3,8:6
// - Field bits select phases A, B, C
// - No phases selected means no pulses
// - Power type fields at pulse cfg 2:0,5:3,8:6
// - Type codes 0..4, others reserved
// - Reset: phases all set, types 0,1,2
// - Threshold stage then 16-bit step divider
// - Divider zero behaves as one
// - Long periods get fixed 80 ms low
// - Short periods: half duty, odd rounds up; divider one gets a fixed 1000 ns low
// - Pins are active low, idle high
// - Disable bits 11:9 hold pins high
// - Falling edge sets flag, mask drives interrupt
// - Flags work while the pin is disabled
// - Step when accumulator reaches chosen threshold
// - Write one clears flag, releases interrupt
`timescale 1ns/1ps
`default_nettype none
`include "etp_defines.svh"
module etp_top #(
   parameter int AW                 = 48,
   parameter int TW                 = 26,
   parameter int LONG_LOW_CYCLES    = `ETP_LONG_LOW_MS * (`ETP_CLK_HZ / 1000),
   parameter int LONG_PERIOD_CYCLES =
      `ETP_LONG_PERIOD_MS * (`ETP_CLK_HZ / 1000)
) (
   // Clock, reset and enable
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   ce,
   // Register port
   input  wire logic                   reg_wr_en,
   input  wire logic                   reg_rd_en,
   input  wire logic [15:0]            reg_addr,
   input  wire logic [31:0]            reg_wdata,
   output logic      [31:0]            reg_rdata,
   output logic                        reg_rd_valid,
   // Phase powers from the metering datapath
   input  wire etp_pkg::etp_power_type power_in [15],
   input  wire logic                   sample_stb,
   input  wire logic [AW-2:0]          active_energy_threshold,
   input  wire logic [AW-2:0]          reactive_energy_threshold,
   input  wire logic [AW-2:0]          apparent_energy_threshold,
   // Shared pin control
   input  wire logic                   fast_capture_enable,
   output logic                        fast_capture_pin_select,
   // Pulse pins and interrupt
   output logic                        pulse_out_one,
   output logic                        pulse_out_two,
   output logic                        pulse_out_three,
   output logic                        interrupt_line_zero_n
);
   logic [15:0] compute_mode_cfg;
   logic [15:0] pulse_output_cfg;
   logic [15:0] pulse_divider_one;
   logic [15:0] pulse_divider_two;
   logic [15:0] pulse_divider_three;
   logic [31:0] irq_status_word0;
   logic [31:0] irq_mask_word0;

   logic [15:0] den_vec [3];
   logic [2:0]  step_vec;
   logic [2:0]  low_vec;
   logic [2:0]  fall_vec;
   logic [2:0]  disable_bits;
   logic        wr_status;
   logic        wr_mask;
   logic [31:0] set_vec;
   logic [31:0] clr_vec;
   logic [31:0] next_status;
   logic [31:0] next_rdata;
   logic        irq_pend;

   ////////////////////////////////////////////////////////////////////////
   // Register writes

   assign wr_status = reg_wr_en && (reg_addr == `ETP_ADDR_IRQ_STATUS);
   assign wr_mask   = reg_wr_en && (reg_addr == `ETP_ADDR_IRQ_MASK);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         compute_mode_cfg    <= `ETP_COMPUTE_MODE_RST;
         pulse_output_cfg    <= `ETP_PULSE_CFG_RST;
         pulse_divider_one   <= `ETP_DIV_RST;
         pulse_divider_two   <= `ETP_DIV_RST;
         pulse_divider_three <= `ETP_DIV_RST;
      end else if (ce && reg_wr_en) begin
         case (reg_addr)
            `ETP_ADDR_COMPUTE_MODE: compute_mode_cfg    <= reg_wdata[15:0];
            `ETP_ADDR_PULSE_CFG:    pulse_output_cfg    <= reg_wdata[15:0];
            `ETP_ADDR_DIV_ONE:      pulse_divider_one   <= reg_wdata[15:0];
            `ETP_ADDR_DIV_TWO:      pulse_divider_two   <= reg_wdata[15:0];
            `ETP_ADDR_DIV_THREE:    pulse_divider_three <= reg_wdata[15:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_mask_word0 <= `ETP_IRQ_RST;
      end else if (ce && wr_mask) begin
         irq_mask_word0 <= reg_wdata & `ETP_FLAG_FIELD;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (reg_addr)
         `ETP_ADDR_IRQ_STATUS:   next_rdata = irq_status_word0;
         `ETP_ADDR_IRQ_MASK:     next_rdata = irq_mask_word0;
         `ETP_ADDR_COMPUTE_MODE: next_rdata = {16'h0000, compute_mode_cfg};
         `ETP_ADDR_PULSE_CFG:    next_rdata = {16'h0000, pulse_output_cfg};
         `ETP_ADDR_DIV_ONE:      next_rdata = {16'h0000, pulse_divider_one};
         `ETP_ADDR_DIV_TWO:      next_rdata = {16'h0000, pulse_divider_two};
         `ETP_ADDR_DIV_THREE:    next_rdata = {16'h0000, pulse_divider_three};
         default:                next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_rdata    <= 32'h0000_0000;
         reg_rd_valid <= 1'b0;
      end else if (ce) begin
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Converters

   assign den_vec[0] = pulse_divider_one;
   assign den_vec[1] = pulse_divider_two;
   assign den_vec[2] = pulse_divider_three;

   for (genvar i = 0; i < 3; i++) begin : g_conv
      etp_conv_if conv_if ();

      assign conv_if.ce  = ce;
      assign conv_if.den = den_vec[i];
      assign step_vec[i] = conv_if.step;
      assign low_vec[i]  = conv_if.pulse_low;
      assign fall_vec[i] = conv_if.fall;
      assign disable_bits[i] = pulse_output_cfg[`ETP_DISABLE_LSB + i];

      etp_first_stage #(
         .AW (AW)
      ) u_stage (
         .clk          (clk),
         .reset_n      (reset_n),
         .conv         (conv_if.stage),
         .power_in     (power_in),
         .sample_stb   (sample_stb),
         .phase_sel    (compute_mode_cfg[`ETP_PHASE_SEL_LSB + 3 * i +:
                                         `ETP_SEL_WIDTH]),
         .power_sel    (pulse_output_cfg[`ETP_POWER_SEL_LSB + 3 * i +:
                                         `ETP_SEL_WIDTH]),
         .thr_active   (active_energy_threshold),
         .thr_reactive (reactive_energy_threshold),
         .thr_apparent (apparent_energy_threshold)
      );

      etp_divider #(
         .TW                 (TW),
         .LONG_LOW_CYCLES    (LONG_LOW_CYCLES),
         .LONG_PERIOD_CYCLES (LONG_PERIOD_CYCLES)
      ) u_divider (
         .clk     (clk),
         .reset_n (reset_n),
         .conv    (conv_if.divider)
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins

   // Active low; a disabled pin, or the shared pin, idles high
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pulse_out_one           <= 1'b1;
         pulse_out_two           <= 1'b1;
         pulse_out_three         <= 1'b1;
         fast_capture_pin_select <= 1'b0;
      end else if (ce) begin
         pulse_out_one   <= disable_bits[0] | ~low_vec[0];
         pulse_out_two   <= disable_bits[1] | ~low_vec[1];
         pulse_out_three <= disable_bits[2] | ~low_vec[2] |
                            fast_capture_enable;
         fast_capture_pin_select <= fast_capture_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags and interrupt

   // Flags come from the converter, not the pin, so disable does not stop them
   assign set_vec = {15'h0000, fall_vec, 14'h0000};
   assign clr_vec = wr_status ? reg_wdata : 32'h0000_0000;
   assign next_status =
      ((irq_status_word0 & ~clr_vec) | set_vec) & `ETP_FLAG_FIELD;
   assign irq_pend = |(irq_status_word0 & irq_mask_word0);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_status_word0 <= `ETP_IRQ_RST;
      end else if (ce) begin
         irq_status_word0 <= next_status;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         interrupt_line_zero_n <= 1'b1;
      end else if (ce) begin
         interrupt_line_zero_n <=
            ~|(irq_status_word0 & irq_mask_word0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   AST_RESET_DEFAULTS: assert property (
      $rose(reset_n) |-> (compute_mode_cfg[8:0] == 9'h1FF &&
                          pulse_output_cfg[11:0] == 12'hE88))
      else $error("configuration reset values wrong");

   AST_DISABLED_HIGH: assert property (
      (ce && pulse_output_cfg[9]) |=> pulse_out_one)
      else $error("disabled pin one went low");

   AST_DISABLED_THREE: assert property (
      (ce && pulse_output_cfg[11]) |=> pulse_out_three)
      else $error("disabled pin three went low");

   AST_SHARED_PIN_QUIET: assert property (
      (ce && fast_capture_enable) |=>
         (pulse_out_three && fast_capture_pin_select))
      else $error("pin three pulsed while fast capture owns it");

   AST_PIN_ACTIVE_LOW: assert property (
      (ce && !pulse_output_cfg[10]) |=> (pulse_out_two == !$past(low_vec[1])))
      else $error("pin two does not follow its pulse");

   AST_FLAG_ON_FALL: assert property (
      (ce && fall_vec[0]) |=> irq_status_word0[14])
      else $error("flag one not set on falling edge");

   AST_FLAG_WHILE_DISABLED: assert property (
      (ce && fall_vec[2] && pulse_output_cfg[11]) |=> irq_status_word0[16])
      else $error("flag three lost while pin disabled");

   AST_IRQ_ASSERTS: assert property (
      (ce && (irq_status_word0 & irq_mask_word0) != 32'h0000_0000) |=>
         !interrupt_line_zero_n)
      else $error("interrupt line not driven low");

   AST_W1C_CLEARS: assert property (
      (ce && wr_status && reg_wdata[15] && !fall_vec[1]) |=>
         !irq_status_word0[15] ##1
         (interrupt_line_zero_n || $past(irq_pend) || !$past(ce)))
      else $error("write one did not clear flag two");

   AST_SET_BEATS_CLEAR: assert property (
      (ce && wr_status && reg_wdata[14] && fall_vec[0]) |=>
         irq_status_word0[14])
      else $error("event lost against its clear");

   AST_NO_PHASES_NO_STEP: assert property (
      (ce && compute_mode_cfg[2:0] == 3'h0) |=> !step_vec[0])
      else $error("step with no phase selected");

   // A low enable must hold registers, flags and pins
   AST_CE_FREEZES: assert property (
      !ce |=> ($stable(pulse_output_cfg) && $stable(pulse_divider_three) &&
               $stable(irq_status_word0) && $stable(pulse_out_one)))
      else $error("state moved while clock enable low");

   COV_CE_HOLD: cover property (!ce ##1 ce);
   COV_PULSE_ONE: cover property (
      !pulse_output_cfg[9] && $fell(pulse_out_one));
   COV_CLEAR_FLAG: cover property (
      irq_status_word0[15] ##1 wr_status ##1 !irq_status_word0[15]);
   COV_SHARED_PIN: cover property (fast_capture_enable && fall_vec[2]);
   COV_IRQ: cover property ($fell(interrupt_line_zero_n));
endmodule
`default_nettype wire

//--- src/etp_defines.svh
// Register map, field positions, reset values and timing figures
`ifndef ETP_DEFINES_SVH
`define ETP_DEFINES_SVH

`define ETP_ADDR_IRQ_STATUS    16'hE502
`define ETP_ADDR_IRQ_MASK      16'hE50A
`define ETP_ADDR_COMPUTE_MODE  16'hE60E
`define ETP_ADDR_PULSE_CFG     16'hE610
`define ETP_ADDR_DIV_ONE       16'hE611
`define ETP_ADDR_DIV_TWO       16'hE612
`define ETP_ADDR_DIV_THREE     16'hE613

// Converter n owns field [LSB + 3n +: 3] or bit [LSB + n]
`define ETP_SEL_WIDTH          3
`define ETP_PHASE_SEL_LSB      0
`define ETP_POWER_SEL_LSB      0
`define ETP_DISABLE_LSB        9
`define ETP_FLAG_LSB           14
`define ETP_FLAG_FIELD         32'h0001_C000

`define ETP_COMPUTE_MODE_RST   16'h01FF
`define ETP_PULSE_CFG_RST      16'h0E88
`define ETP_DIV_RST            16'h0000
`define ETP_IRQ_RST            32'h0000_0000

`define ETP_PT_TOTAL_ACTIVE    3'h0
`define ETP_PT_TOTAL_REACTIVE  3'h1
`define ETP_PT_APPARENT        3'h2
`define ETP_PT_FUND_ACTIVE     3'h3
`define ETP_PT_FUND_REACTIVE   3'h4

`define ETP_CLK_HZ             200000000
`define ETP_LONG_LOW_MS        80
`define ETP_LONG_PERIOD_MS     160
`define ETP_DEN_ONE_LOW_NS     1000
`define ETP_DEN_ONE_LOW_CYCLES \
   ((`ETP_DEN_ONE_LOW_NS * (`ETP_CLK_HZ / 1000000)) / 1000)

`endif

//--- src/etp_pkg.sv
// Shared types of the energy-to-pulse converter
package etp_pkg;
   typedef logic signed [27:0] etp_power_type;
   typedef enum logic {ETP_PULSE_HIGH, ETP_PULSE_LOW} etp_pulse_state_type;
endpackage

//--- src/etp_conv_if.sv
// Link between the two stages of one converter and the top
`timescale 1ns/1ps
`default_nettype none
interface etp_conv_if;
   logic        ce;
   logic        step;
   logic [15:0] den;
   logic        pulse_low;
   logic        fall;
   modport stage   (input ce, output step);
   modport divider (input ce, input step, input den,
                    output pulse_low, output fall);
   modport top     (output ce, output den,
                    input step, input pulse_low, input fall);
endinterface
`default_nettype wire

//--- src/etp_first_stage.sv
// First stage: sum of selected phase powers against an energy threshold
`timescale 1ns/1ps
`default_nettype none
`include "etp_defines.svh"
module etp_first_stage #(
   parameter int AW = 48
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   // Converter link
   etp_conv_if.stage                  conv,
   // Power samples, index is type * 3 + phase
   input  wire etp_pkg::etp_power_type power_in [15],
   input  wire logic                  sample_stb,
   // Selections
   input  wire logic [2:0]            phase_sel,
   input  wire logic [2:0]            power_sel,
   // Energy thresholds
   input  wire logic [AW-2:0]         thr_active,
   input  wire logic [AW-2:0]         thr_reactive,
   input  wire logic [AW-2:0]         thr_apparent
);
   logic signed [AW-1:0] acc;
   logic signed [AW-1:0] sum;
   logic signed [AW-1:0] acc_sum;
   logic signed [AW-1:0] thr;
   logic        [AW-2:0] thr_raw;
   logic                 valid_type;

   always_comb begin
      sum        = '0;
      valid_type = (power_sel <= `ETP_PT_FUND_REACTIVE);
      for (int p = 0; p < 3; p++) begin
         if (valid_type && phase_sel[p]) begin
            sum = sum + AW'(power_in[power_sel * 3 + p]);
         end
      end
      case (power_sel)
         `ETP_PT_TOTAL_REACTIVE, `ETP_PT_FUND_REACTIVE: thr_raw = thr_reactive;
         `ETP_PT_APPARENT:                              thr_raw = thr_apparent;
         default:                                       thr_raw = thr_active;
      endcase
      thr = $signed({1'b0, thr_raw});
      if (thr_raw == '0) begin
         thr = AW'(1);
      end
      acc_sum = acc + sum;
   end

   // Signed accumulation, one step per threshold crossing either way
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         acc       <= '0;
         conv.step <= 1'b0;
      end else if (conv.ce) begin
         conv.step <= 1'b0;
         if (phase_sel == 3'h0 || !valid_type) begin
            acc <= '0;
         end else if (sample_stb) begin
            if (acc_sum >= thr) begin
               acc       <= acc_sum - thr;
               conv.step <= 1'b1;
            end else if (acc_sum <= -thr) begin
               acc       <= acc_sum + thr;
               conv.step <= 1'b1;
            end else begin
               acc <= acc_sum;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- src/etp_divider.sv
// Second stage: step divider and pulse shaper
`timescale 1ns/1ps
`default_nettype none
`include "etp_defines.svh"
module etp_divider #(
   parameter int TW                 = 26,
   parameter int LONG_LOW_CYCLES    = 16000000,
   parameter int LONG_PERIOD_CYCLES = 32000000
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Converter link
   etp_conv_if.divider conv
);
   localparam logic [TW-1:0] LOW_END  = TW'(LONG_LOW_CYCLES - 1);
   localparam logic [TW-1:0] LONG_PER = TW'(LONG_PERIOD_CYCLES);
   localparam logic [TW-1:0] ONE_END  = TW'(`ETP_DEN_ONE_LOW_CYCLES - 1);

   etp_pkg::etp_pulse_state_type state;
   logic [15:0]   den_eff;
   logic [16:0]   half;
   logic [15:0]   step_cnt;
   logic [TW-1:0] period_cnt;
   logic [TW-1:0] low_cnt;
   logic          long_mode;
   logic          boundary;
   logic          release_low;
   logic          in_low;

   always_comb begin
      den_eff  = (conv.den == 16'h0000) ? 16'h0001 : conv.den;
      half     = ({1'b0, den_eff} + 17'h00001) >> 1;
      in_low   = (state == etp_pkg::ETP_PULSE_LOW);
      boundary = conv.step &&
                 (({1'b0, step_cnt} + 17'h00001) >= {1'b0, den_eff});
      if (long_mode) begin
         release_low = in_low && (low_cnt >= LOW_END);
      end else if (den_eff == 16'h0001) begin
         release_low = in_low && (low_cnt >= ONE_END);
      end else begin
         release_low = in_low && conv.step &&
                       (({1'b0, step_cnt} + 17'h00001) >= half);
      end
   end

   assign conv.pulse_low = in_low;

   // Step count and period length since the last boundary
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         step_cnt   <= 16'h0000;
         period_cnt <= '0;
         long_mode  <= 1'b1;
      end else if (conv.ce) begin
         if (boundary) begin
            step_cnt   <= 16'h0000;
            period_cnt <= '0;
            long_mode  <= (period_cnt >= LONG_PER);
         end else begin
            if (conv.step) begin
               step_cnt <= step_cnt + 16'h0001;
            end
            if (period_cnt != '1) begin
               period_cnt <= period_cnt + TW'(1);
            end
         end
      end
   end

   // Pulse state, low time and falling-edge event
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state     <= etp_pkg::ETP_PULSE_HIGH;
         low_cnt   <= '0;
         conv.fall <= 1'b0;
      end else if (conv.ce) begin
         conv.fall <= boundary && !in_low;
         if (boundary) begin
            state   <= etp_pkg::ETP_PULSE_LOW;
            low_cnt <= '0;
         end else begin
            if (release_low) begin
               state <= etp_pkg::ETP_PULSE_HIGH;
            end
            if (in_low && low_cnt != '1) begin
               low_cnt <= low_cnt + TW'(1);
            end
         end
      end
   end

   AST_LOW_AT_BOUNDARY: assert property (@(posedge clk) disable iff (!reset_n)
      (conv.ce && boundary) |=> in_low)
      else $error("pulse not low after period boundary");
endmodule
`default_nettype wire

//--- testbench/etp_led_probe.sv
// Optical pickup model: counts pulse falls and the last low width
`timescale 1ns/1ps
`default_nettype none
module etp_led_probe (
   // Clock and watched pin
   input  wire logic       clk,
   input  wire logic       pin,
   // What the pickup saw
   output var logic [15:0] falls,
   output var logic [15:0] width
);
   logic        last = 1'b1;
   logic [15:0] run  = 16'h0000;
   initial falls = 16'h0000;
   initial width = 16'h0000;
   // LED lights while the pin is low
   always @(posedge clk) begin
      last <= pin;
      if (last === 1'b1 && pin === 1'b0) falls <= falls + 16'h0001;
      if (pin === 1'b0) run <= run + 16'h0001;
      else if (last === 1'b0) begin
         width <= run;
         run   <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

//--- testbench/energy_to_pulse_converter_bench.sv
// Self-checking bench of the energy-to-pulse converter
`timescale 1ns/1ps
`default_nettype none
`include "etp_defines.svh"
module energy_to_pulse_converter_bench;
   logic             clk     = 1'b0;
   logic             reset_n = 1'b0;
   logic             ce      = 1'b1;
   logic             rd      = 1'b0;
   logic             wr      = 1'b0;
   logic [15:0]      addr    = 16'h0000;
   logic [31:0]      wdata   = 32'h0000_0000;
   logic [31:0]      rdata;
   logic             rvalid;
   logic             stb     = 1'b0;
   logic             fce     = 1'b0;
   logic             fsel;
   logic             irq_n;
   logic [46:0]      thr     = 47'h3;
   logic [2:0]       pins;
   logic [2:0][15:0] falls;
   logic [2:0][15:0] widths;
   logic [2:0][15:0] dlt;
   etp_pkg::etp_power_type pw [15];
   int               n_errors  = 0;
   int               tests_run = 0;

   always #2.5 clk = ~clk;

   etp_top #(.LONG_LOW_CYCLES(150), .LONG_PERIOD_CYCLES(400)) etp_top_inst (
      .clk(clk), .reset_n(reset_n), .ce(ce),
      .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata(rdata), .reg_rd_valid(rvalid),
      .power_in(pw), .sample_stb(stb), .active_energy_threshold(thr),
      .reactive_energy_threshold(thr), .apparent_energy_threshold(thr),
      .fast_capture_enable(fce), .fast_capture_pin_select(fsel),
      .pulse_out_one(pins[0]), .pulse_out_two(pins[1]),
      .pulse_out_three(pins[2]), .interrupt_line_zero_n(irq_n));

   etp_led_probe etp_led_probe_inst [2:0] (
      .clk(clk), .pin(pins), .falls(falls), .width(widths));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] seen);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk) #1;
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk) #1;
      wr = 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [15:0] a,
                         input logic [31:0] exp);
      @(posedge clk) #1;
      rd = 1'b1;
      addr = a;
      @(posedge clk) #1;
      rd = 1'b0;
      chk("read valid", 32'h1, {31'h0, rvalid});
      chk(what, exp, rdata);
   endtask

   // Sample strobes gap cycles apart, then a settle time
   task automatic run(input int n, input int gap);
      logic [2:0][15:0] base;
      base = falls;
      repeat (n) begin
         @(posedge clk) #1;
         stb = 1'b1;
         @(posedge clk) #1;
         stb = 1'b0;
         repeat (gap - 2) @(posedge clk);
      end
      repeat (12) @(posedge clk);
      #1;
      for (int i = 0; i < 3; i++) dlt[i] = falls[i] - base[i];
   endtask

   // Power of one type only (each phase 1), or every type when c < 0
   task automatic set_pw(input int c);
      for (int k = 0; k < 15; k++) begin
         pw[k] = (c < 0 || k / 3 == c) ? 28'sh1 : 28'sh0;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_chk("compute mode", `ETP_ADDR_COMPUTE_MODE, 32'h0000_01FF);
      rd_chk("pulse cfg", `ETP_ADDR_PULSE_CFG, 32'h0000_0E88);
      rd_chk("status", `ETP_ADDR_IRQ_STATUS, 32'h0000_0000);
      chk("pins idle", 32'h7, {29'h0, pins});
      wr_reg(`ETP_ADDR_DIV_TWO, 32'h0001_ABCD);
      rd_chk("divider two", `ETP_ADDR_DIV_TWO, 32'h0000_ABCD);
      wr_reg(16'hE614, 32'h0000_1234);
      rd_chk("unmapped", 16'hE614, 32'h0000_0000);
      ce = 1'b0;
      wr_reg(`ETP_ADDR_DIV_THREE, 32'h0000_0005);
      ce = 1'b1;
      rd_chk("frozen write", `ETP_ADDR_DIV_THREE, 32'h0);
   endtask

   task automatic t_flags();
      wr_reg(`ETP_ADDR_DIV_ONE, 32'h2);
      wr_reg(`ETP_ADDR_DIV_TWO, 32'h2);
      wr_reg(`ETP_ADDR_DIV_THREE, 32'h2);
      wr_reg(`ETP_ADDR_IRQ_MASK, 32'h0001_C000);
      run(2, 250);
      chk("disabled falls", 32'h0,
          {16'h0, dlt[0] | dlt[1] | dlt[2]});
      rd_chk("flags", `ETP_ADDR_IRQ_STATUS, 32'h0001_C000);
      chk("irq set", 32'h0, {31'h0, irq_n});
      wr_reg(`ETP_ADDR_IRQ_STATUS, 32'h0000_4000);
      rd_chk("one cleared", `ETP_ADDR_IRQ_STATUS, 32'h0001_8000);
      wr_reg(`ETP_ADDR_IRQ_STATUS, 32'h0001_8000);
      repeat (2) @(posedge clk);
      #1;
      chk("irq released", 32'h1, {31'h0, irq_n});
   endtask

   // Only phase A of type 0 carries power; one phase bit set at a time
   task automatic t_phase();
      set_pw(0);
      pw[1] = 28'sh0;
      pw[2] = 28'sh0;
      pw[0] = 28'sh3;
      wr_reg(`ETP_ADDR_PULSE_CFG, 32'h0);
      for (int k = 0; k < 9; k++) begin
         wr_reg(`ETP_ADDR_COMPUTE_MODE, 32'(1) << k);
         run(2, 250);
         for (int n = 0; n < 3; n++)
            chk("phase falls", {31'h0, k == 3 * n},
                {16'h0, dlt[n]});
      end
   endtask

   task automatic t_types();
      wr_reg(`ETP_ADDR_COMPUTE_MODE, 32'h0000_01FF);
      for (int c = 0; c < 5; c++) begin
         set_pw(c);
         wr_reg(`ETP_ADDR_PULSE_CFG, 32'(c));
         run(2, 250);
         chk("type falls", 32'h1, {16'h0, dlt[0]});
      end
      set_pw(-1);
      wr_reg(`ETP_ADDR_COMPUTE_MODE, 32'h0000_01C7);
      wr_reg(`ETP_ADDR_PULSE_CFG, 32'h0000_0148);
      run(4, 250);
      chk("one falls", 32'h2, {16'h0, dlt[0]});
      chk("no phases", 32'h0, {16'h0, dlt[1]});
      chk("reserved", 32'h0, {16'h0, dlt[2]});
      wr_reg(`ETP_ADDR_COMPUTE_MODE, 32'h0000_01FF);
      wr_reg(`ETP_ADDR_PULSE_CFG, 32'h0);
   endtask

   task automatic t_shape();
      run(2, 600);
      repeat (200) @(posedge clk);
      #1;
      chk("long low", 32'h0000_0096, {16'h0, widths[0]});
      wr_reg(`ETP_ADDR_DIV_ONE, 32'h0);
      run(4, 250);
      chk("zero falls", 32'h4, {16'h0, dlt[0]});
      chk("zero low", 32'h0000_00C8, {16'h0, widths[0]});
      for (int d = 3; d < 5; d++) begin
         wr_reg(`ETP_ADDR_DIV_ONE, 32'(d));
         run(60, 10);
         chk("short low", 32'((d + 1) / 2 * 10),
             {16'h0, widths[0]});
      end
   endtask

   task automatic t_fast();
      fce = 1'b1;
      run(4, 250);
      chk("pin select", 32'h1, {31'h0, fsel});
      chk("three quiet", 32'h0, {16'h0, dlt[2]});
      chk("two falls", 32'h2, {16'h0, dlt[1]});
      fce = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      set_pw(-1);
      repeat (16) @(posedge clk);
      #1;
      reset_n = 1'b1;
      t_reset();
      t_flags();
      t_phase();
      t_types();
      t_shape();
      t_fast();
      report_and_stop();
   end

   // Watchdog well past the expected run length
   initial begin
      #300000;
      n_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
